/* File: design/code_rom.sv */
// Program ROM with a load port for its mask contents
`timescale 1ns/1ps
module code_rom
    import memmap_pkg::*;
#(
    parameter int DEPTH = ROM_DEPTH,
    parameter int WIDTH = ROM_WIDTH
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    // Content load
    input  wire logic             load_we_in,
    input  wire logic [15:0]      load_addr_in,
    input  wire logic [WIDTH-1:0] load_data_in,
    // Fetch
    input  wire logic             fetch_in,
    input  wire logic [15:0]      fetch_addr_in,
    output logic      [WIDTH-1:0] fetch_data_out,
    output logic                  fetch_valid_out
);
    logic [WIDTH-1:0] rom [DEPTH];

    always_ff @(posedge clk_in) begin
        if (load_we_in && load_addr_in <= ROM_LAST) begin
            rom[load_addr_in[12:0]] <= load_data_in;
        end
    end

    // Steps above the program area answer zero, not valid
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            fetch_data_out  <= '0;
            fetch_valid_out <= 1'b0;
        end else if (fetch_in && fetch_addr_in <= ROM_LAST) begin // [RL1]
            fetch_data_out  <= rom[fetch_addr_in[12:0]];
            fetch_valid_out <= 1'b1;
        end else begin
            fetch_data_out  <= '0;
            fetch_valid_out <= 1'b0;
        end
    end

endmodule : code_rom

/* File: design/data_ram.sv */
// Nibble RAM with one nibble port and one 16-bit write port
`timescale 1ns/1ps
module data_ram
    import memmap_pkg::*;
#(
    parameter int WORDS = 1024
) (
    // Clock
    input  wire logic        clk_in,
    // Nibble port
    input  wire logic        nib_we_in,
    input  wire logic [9:0]  nib_addr_in,
    input  wire logic [3:0]  nib_wdata_in,
    input  wire logic [9:0]  rd_addr_in,
    output logic      [3:0]  rd_data_out,
    // Wide port, low nibble at lowest address
    input  wire logic        wide_we_in,
    input  wire logic [9:0]  wide_addr_in,
    input  wire logic [15:0] wide_wdata_in
);
    logic [3:0] mem [WORDS];

    always_ff @(posedge clk_in) begin
        if (nib_we_in) begin
            mem[nib_addr_in] <= nib_wdata_in;
        end
        if (wide_we_in) begin
            for (int i = 0; i < 4; i++) begin
                mem[wide_addr_in + 10'(i)] <= wide_wdata_in[4*i +: 4];
            end
        end
    end

    assign rd_data_out = mem[rd_addr_in];

endmodule : data_ram

/* File: design/memmap_core.sv */
// Data memory decode, stack pushes, interrupt gating and system registers
`timescale 1ns/1ps
module memmap_core
    import memmap_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 srst_in,
    // CPU data bus
    input  wire mem_req_t             bus_req_in,
    output logic                      bus_ready_out,
    output logic                      bus_ack_out,
    output logic      [3:0]           bus_rdata_out,
    // Code fetch and vectors
    input  wire logic                 fetch_in,
    input  wire logic [15:0]          fetch_addr_in,
    output logic      [ROM_WIDTH-1:0] fetch_data_out,
    output logic                      fetch_valid_out,
    output logic      [15:0]          start_addr_out,
    input  wire logic [2:0]           irq_num_in,
    output logic      [15:0]          vector_out,
    // ROM content load
    input  wire logic                 rom_we_in,
    input  wire logic [15:0]          rom_addr_in,
    input  wire logic [ROM_WIDTH-1:0] rom_data_in,
    // Stack pointers
    input  wire logic                 wide_sp_load_in,
    input  wire logic [7:0]           wide_sp_value_in,
    input  wire logic                 nib_sp_load_in,
    input  wire logic [7:0]           nib_sp_value_in,
    output logic      [7:0]           wide_stack_pointer_out,
    output logic      [7:0]           nibble_stack_pointer_out,
    // Stack pushes
    input  wire logic                 call_push_in,
    input  wire logic                 irq_push_in,
    input  wire logic [15:0]          pc_in,
    input  wire logic [3:0]           flags_in,
    output logic                      push_done_out,
    output logic                      stack_fault_out,
    // Interrupts
    input  wire logic                 nmi_in,
    input  wire logic                 irq_in,
    output logic                      nmi_out,
    output logic                      irq_out,
    output logic                      irq_masked_out,
    // Sleep request
    input  wire logic                 sleep_instruction_in,
    output logic                      sleep_ignored_out,
    // System controls
    output sys_ctrl_t                 sys_ctrl_out,
    // Custom block area
    output logic      [5:0]           cust_rd_addr_out,
    input  wire logic [3:0]           cust_rdata_in,
    output logic                      cust_wr_out,
    output logic      [5:0]           cust_addr_out,
    output logic      [3:0]           cust_wdata_out,
    // Display memory read-out
    input  wire logic [4:0]           disp_rd_addr_in,
    output logic      [3:0]           disp_rd_data_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_PC, ST_FLAG} push_st_t;

    push_st_t    st;
    logic        is_irq;
    logic [15:0] pc_q;
    logic [3:0]  flag_q;
    logic [7:0]  wide_sp;
    logic [7:0]  nib_sp;
    logic        wide_set;
    logic        nib_set;
    logic [3:0]  disp_mem [32];
    logic [3:0]  ram_rd;
    logic        bus_rd;
    logic        bus_wr;
    logic        wide_ok;
    logic        push_start;
    region_t     rgn;
    sys_ctrl_t   ctrl;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic region_t region_of(input logic [15:0] a);
        if (a <= RAM_LAST) begin
            return REG_RAM; // [RL4]
        end else if (a >= DISP_BASE && a < DISP_BASE + DISP_WORDS) begin
            return REG_DISP; // [RL14]
        end else if (a >= IO_BASE && a < IO_BASE + IO_WORDS) begin
            return REG_IO; // [RL13]
        end else if (a >= CUST_BASE) begin
            return REG_CUST; // [RL14]
        end
        return REG_NONE;
    endfunction : region_of

    function automatic logic [3:0] io_read(input logic [15:0] a);
        unique case (a)
            CLK_VOLT_ADDR: return {ctrl.cpu_clock_source_sel, ctrl.fast_osc_on,
                                   1'b0, ctrl.core_voltage_sel}; // [RL16]
            SUPPLY_ADDR:   return {ctrl.display_supply_sel, ctrl.osc_regulator_supply_sel,
                                   ctrl.halver_on, ctrl.doubler_on}; // [RL17]
            PRESCALE_ADDR: return {2'b00, ctrl.prescaler_sel}; // [RL20]
            THRESH_ADDR:   return ctrl.detect_threshold_code; // [RL18]
            default:       return 4'h0; // [RL20]
        endcase
    endfunction : io_read

    assign rgn           = region_of(bus_req_in.addr);
    assign bus_ready_out = (st == ST_IDLE);
    assign bus_rd        = bus_req_in.rd && bus_ready_out;
    assign bus_wr        = bus_req_in.wr && bus_ready_out;
    assign push_start    = (st == ST_IDLE) && (call_push_in || irq_push_in);
    assign wide_ok       = (wide_sp[7:6] == 2'b01); // [RL5]
    assign sys_ctrl_out  = ctrl;
    assign cust_rd_addr_out = bus_req_in.addr[5:0];
    assign wide_stack_pointer_out   = wide_sp;
    assign nibble_stack_pointer_out = nib_sp;
    assign start_addr_out = START_ADDR; // [RL2]
    assign vector_out     = NMI_VEC + {12'h000, irq_num_in, 1'b0}; // [RL3]

    // ------------------------------------------------------------
    // Memories
    // ------------------------------------------------------------
    data_ram u_ram (
        .clk_in        (clk_in),
        .nib_we_in     ((st == ST_FLAG) || (bus_wr && rgn == REG_RAM)),
        .nib_addr_in   ((st == ST_FLAG) ? {2'b00, nib_sp} : bus_req_in.addr[9:0]),
        .nib_wdata_in  ((st == ST_FLAG) ? flag_q : bus_req_in.wdata),
        .rd_addr_in    (bus_req_in.addr[9:0]),
        .rd_data_out   (ram_rd),
        .wide_we_in    ((st == ST_PC) && wide_ok), // [RL7]
        .wide_addr_in  ({wide_sp, 2'b00}),
        .wide_wdata_in (pc_q)
    );

    code_rom u_rom (
        .clk_in          (clk_in),
        .srst_in         (srst_in),
        .load_we_in      (rom_we_in),
        .load_addr_in    (rom_addr_in),
        .load_data_in    (rom_data_in),
        .fetch_in        (fetch_in),
        .fetch_addr_in   (fetch_addr_in),
        .fetch_data_out  (fetch_data_out),
        .fetch_valid_out (fetch_valid_out)
    );

    always_ff @(posedge clk_in) begin
        if (bus_wr && rgn == REG_DISP) begin
            disp_mem[bus_req_in.addr[4:0]] <= bus_req_in.wdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            disp_rd_data_out <= 4'h0;
        end else begin
            disp_rd_data_out <= disp_mem[disp_rd_addr_in];
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            bus_ack_out   <= 1'b0;
            bus_rdata_out <= 4'h0;
        end else begin
            bus_ack_out <= bus_rd || bus_wr;
            if (bus_rd) begin
                unique case (rgn)
                    REG_RAM:  bus_rdata_out <= ram_rd;
                    REG_DISP: bus_rdata_out <= disp_mem[bus_req_in.addr[4:0]];
                    REG_IO:   bus_rdata_out <= io_read(bus_req_in.addr);
                    REG_CUST: bus_rdata_out <= cust_rdata_in;
                    REG_NONE: bus_rdata_out <= 4'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cust_wr_out    <= 1'b0;
            cust_addr_out  <= 6'h00;
            cust_wdata_out <= 4'h0;
        end else begin
            cust_wr_out <= bus_wr && rgn == REG_CUST;
            if (bus_wr && rgn == REG_CUST) begin
                cust_addr_out  <= bus_req_in.addr[5:0];
                cust_wdata_out <= bus_req_in.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // System registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl <= '{prescaler_sel: PRESCALE_RST, detect_threshold_code: CTRL_RST,
                      default: 1'b0}; // [RL19]
        end else if (bus_wr && rgn == REG_IO) begin
            unique case (bus_req_in.addr)
                CLK_VOLT_ADDR: begin
                    ctrl.cpu_clock_source_sel <= bus_req_in.wdata[CLK_SEL_BIT]; // [RL16]
                    ctrl.fast_osc_on          <= bus_req_in.wdata[FAST_OSC_BIT];
                    ctrl.core_voltage_sel     <= bus_req_in.wdata[VOLT_BIT];
                end
                SUPPLY_ADDR: begin
                    ctrl.display_supply_sel       <= bus_req_in.wdata[3]; // [RL17]
                    ctrl.osc_regulator_supply_sel <= bus_req_in.wdata[2];
                    ctrl.halver_on                <= bus_req_in.wdata[1];
                    ctrl.doubler_on               <= bus_req_in.wdata[0];
                end
                PRESCALE_ADDR: ctrl.prescaler_sel <= bus_req_in.wdata[1:0]; // [RL20]
                THRESH_ADDR:   ctrl.detect_threshold_code <= bus_req_in.wdata; // [RL18]
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Stack push engine
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st     <= ST_IDLE;
            is_irq <= 1'b0;
            pc_q   <= 16'h0000;
            flag_q <= 4'h0;
        end else begin
            unique case (st)
                ST_IDLE: if (push_start) begin
                    st     <= ST_PC;
                    is_irq <= irq_push_in; // [RL11]
                    pc_q   <= pc_in; // [RL10]
                    flag_q <= flags_in;
                end
                ST_PC:   st <= is_irq ? ST_FLAG : ST_IDLE;
                ST_FLAG: st <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            push_done_out   <= 1'b0;
            stack_fault_out <= 1'b0;
        end else begin
            push_done_out   <= (st == ST_FLAG) || (st == ST_PC && !is_irq);
            stack_fault_out <= (st == ST_PC) && !wide_ok; // [RL5]
        end
    end

    // Pointers pre-decrement and wrap by their own width
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wide_sp <= 8'h00;
            nib_sp  <= 8'h00;
        end else begin
            if (push_start) begin
                wide_sp <= wide_sp - 8'h01; // [RL6]
            end else if (wide_sp_load_in && st == ST_IDLE) begin
                wide_sp <= wide_sp_value_in;
            end
            if (st == ST_PC && is_irq) begin
                nib_sp <= nib_sp - 8'h01; // [RL6]
            end else if (nib_sp_load_in && st == ST_IDLE) begin
                nib_sp <= nib_sp_value_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt masking
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wide_set <= 1'b0; // [RL8]
            nib_set  <= 1'b0;
        end else begin
            if (wide_sp_load_in && st == ST_IDLE) begin
                wide_set <= 1'b1;
                if (wide_set && nib_set && !nib_sp_load_in) begin
                    nib_set <= 1'b0; // [RL9]
                end
            end
            if (nib_sp_load_in && st == ST_IDLE) begin
                nib_set <= 1'b1;
                if (wide_set && nib_set && !wide_sp_load_in) begin
                    wide_set <= 1'b0; // [RL9]
                end
            end
        end
    end

    assign irq_masked_out = !(wide_set && nib_set);
    assign nmi_out        = nmi_in && !irq_masked_out; // [RL8]
    assign irq_out        = irq_in && !irq_masked_out;

    // Sleep is never honoured; the core keeps running
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sleep_ignored_out <= 1'b0;
        end else begin
            sleep_ignored_out <= sleep_instruction_in; // [RL12]
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    logic [15:0] rd_addr_q;
    always_ff @(posedge clk_in) begin
        rd_addr_q <= bus_req_in.addr;
    end

    sequence s_pc_phase;
        st == ST_PC;
    endsequence
    sequence s_flag_phase;
        st == ST_FLAG;
    endsequence

    AST_MASK_AFTER_RESET: assert property ($fell(srst_in) |-> irq_masked_out) // [RL8]
        else $error("interrupts not masked after reset");
    AST_NMI_GATED: assert property (irq_masked_out |-> !nmi_out && !irq_out) // [RL8]
        else $error("interrupt passed while masked");
    AST_REMASK: assert property (!irq_masked_out && st == ST_IDLE && wide_sp_load_in
                                 && !nib_sp_load_in |=> irq_masked_out) // [RL9]
        else $error("rewrite of one pointer did not remask");
    AST_WIDE_WRAP: assert property (push_start |=> wide_sp == $past(wide_sp) - 8'h01) // [RL6]
        else $error("wide pointer did not step down");
    AST_IRQ_PUSH: assert property (push_start && irq_push_in |=> s_pc_phase ##1 s_flag_phase
                                   ##1 st == ST_IDLE && push_done_out) // [RL11]
        else $error("interrupt push sequence wrong");
    AST_CALL_PUSH: assert property (push_start && !irq_push_in |=> s_pc_phase
                                    ##1 st == ST_IDLE && push_done_out) // [RL10]
        else $error("call push sequence wrong");
    AST_PRESCALE_RESET: assert property ($fell(srst_in) |-> ctrl.prescaler_sel == 2'h3) // [RL19]
        else $error("prescaler reset value wrong");
    AST_RESERVED_ZERO: assert property (bus_ack_out && $past(bus_rd) && rd_addr_q == CLK_VOLT_ADDR
                                        |-> bus_rdata_out[1] == 1'b0) // [RL16]
        else $error("reserved bit read nonzero");

endmodule : memmap_core

/* File: design/memmap_pkg.sv */
// Memory map constants, types and field layout
//
// Operation
// RL1: Code ROM answers only steps 0000H-1FFFH
// RL2: Execution starts at step 0110H after reset
// RL3: NMI vector 0100H, others 0102H-010EH
// RL4: 1024 nibbles of RAM at 0000H-03FFH
// RL5: Wide access only inside 0100H-01FFH
// RL6: Wide pointer wraps 03FFH, nibble pointer 00FFH
// RL7: Only wide-pointer stack writes are 16-bit
// RL8: Interrupts masked until both pointers written
// RL9: Rewriting one pointer remasks until other rewritten
// RL10: Call pushes PC as four nibbles
// RL11: Interrupt pushes PC and one flag nibble
// RL12: No sleep; sleep instruction never halts
// RL13: Peripherals reached by plain memory accesses
// RL14: Decode display, peripheral and custom areas
// RL15: Software avoids unused addresses
// RL16: Clock, fast oscillator, voltage bits at CPU_CLOCK_AND_VOLTAGE_CTRL
// RL17: Supply source and pump bits at SUPPLY_SOURCE_AND_PUMP_CTRL
// RL18: Detection threshold code at VOLTAGE_DETECT_THRESHOLD
// RL19: Prescaler field resets to 153.6 kHz
// RL20: Unused I/O bits read zero, ignore writes
package memmap_pkg;

    // ------------------------------------------------------------
    // Code space
    // ------------------------------------------------------------
    localparam logic [15:0] ROM_LAST     = 16'h1fff;
    localparam logic [15:0] START_ADDR   = 16'h0110;
    localparam logic [15:0] NMI_VEC      = 16'h0100;
    localparam int          ROM_WIDTH    = 13;
    localparam int          ROM_DEPTH    = 8192;

    // ------------------------------------------------------------
    // Data space
    // ------------------------------------------------------------
    localparam logic [15:0] RAM_LAST     = 16'h03ff;
    localparam logic [15:0] WIDE_LO      = 16'h0100;
    localparam logic [15:0] WIDE_HI      = 16'h01ff;
    localparam logic [15:0] DISP_BASE    = 16'hf000;
    localparam logic [15:0] DISP_WORDS   = 16'h0020;
    localparam logic [15:0] IO_BASE      = 16'hff00;
    localparam logic [15:0] IO_WORDS     = 16'h003f;
    localparam logic [15:0] CUST_BASE    = 16'hffc0;
    localparam logic [15:0] CUST_WORDS   = 16'h0040;

    // ------------------------------------------------------------
    // I/O registers and fields
    // ------------------------------------------------------------
    localparam logic [15:0] CLK_VOLT_ADDR = 16'hff00;
    localparam logic [15:0] SUPPLY_ADDR   = 16'hff01;
    localparam logic [15:0] PRESCALE_ADDR = 16'hff02;
    localparam logic [15:0] THRESH_ADDR   = 16'hff04;
    localparam int          CLK_SEL_BIT   = 3;
    localparam int          FAST_OSC_BIT  = 2;
    localparam int          VOLT_BIT      = 0;
    localparam logic [3:0]  CTRL_RST      = 4'h0;
    localparam logic [1:0]  PRESCALE_RST  = 2'h3;

    typedef enum logic [2:0] {REG_RAM, REG_DISP, REG_IO, REG_CUST, REG_NONE} region_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [3:0]  wdata;
    } mem_req_t;

    typedef struct packed {
        logic       cpu_clock_source_sel;
        logic       fast_osc_on;
        logic       core_voltage_sel;
        logic       display_supply_sel;
        logic       osc_regulator_supply_sel;
        logic       halver_on;
        logic       doubler_on;
        logic [1:0] prescaler_sel;
        logic [3:0] detect_threshold_code;
    } sys_ctrl_t;

endpackage : memmap_pkg

/* File: tb/cpu_model.sv */
// CPU-side model of the data memory bus
`timescale 1ns/1ps
module cpu_model
    import memmap_pkg::*;
(
    // Clock
    input  wire logic       clk_in,
    // Bus answer
    input  wire logic       bus_ready_in,
    input  wire logic       bus_ack_in,
    input  wire logic [3:0] bus_rdata_in,
    // Bus request
    output mem_req_t        bus_req_out
);
    initial bus_req_out = '0;

    // ----------------------------------------
    // Nibble access, held until taken
    // ----------------------------------------
    task automatic access(input logic wr, input logic [15:0] addr, input logic [3:0] wdata,
                          output logic ack, output logic [3:0] rdata);
        logic rdy;
        @(posedge clk_in);
        bus_req_out <= '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
        do begin
            @(negedge clk_in);
            rdy = bus_ready_in;
            @(posedge clk_in);
        end while (rdy !== 1'b1);
        // Released lines show the inverse, never the last value
        bus_req_out <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        #1;
        ack = bus_ack_in;
        rdata = bus_rdata_in;
    endtask : access
endmodule : cpu_model

/* File: tb/memory_map_and_system_regs_tb.sv */
// Self-checking bench for the memory map and system registers
`timescale 1ns/1ps
module memory_map_and_system_regs_tb
    import memmap_pkg::*;
;
    logic                 clk_in = 1'b0;
    logic                 srst_in = 1'b1;
    mem_req_t             req;
    logic                 ready, ack, fvalid, done, fault, nmi_o, irq_o, masked, slp_o, c_wr;
    logic [3:0]           rdata, c_wd, d_d, flags = '0;
    logic [15:0]          start_a, vec, faddr = '0, rom_a = '0, pc = '0;
    logic [ROM_WIDTH-1:0] fdata, rom_d = '0;
    logic [7:0]           wsp, nsp, wval = '0, nval = '0;
    logic [5:0]           c_a;
    logic [4:0]           d_a = '0;
    logic [2:0]           irq_num = '0;
    logic                 fetch = 0, rom_we = 0, wld = 0, nld = 0, callp = 0, irqp = 0, int_req = 0, sleep_instruction = 0;
    logic [9:0]           last_c;
    sys_ctrl_t            sys;
    int                   n_mismatch = 0, checked = 0, n_done = 0, n_fault = 0;

    memmap_core u_memmap_core (.clk_in(clk_in), .srst_in(srst_in), .bus_req_in(req), .bus_ready_out(ready),
        .bus_ack_out(ack), .bus_rdata_out(rdata), .fetch_in(fetch), .fetch_addr_in(faddr),
        .fetch_data_out(fdata), .fetch_valid_out(fvalid), .start_addr_out(start_a), .irq_num_in(irq_num),
        .vector_out(vec), .rom_we_in(rom_we), .rom_addr_in(rom_a), .rom_data_in(rom_d),
        .wide_sp_load_in(wld), .wide_sp_value_in(wval), .nib_sp_load_in(nld), .nib_sp_value_in(nval),
        .wide_stack_pointer_out(wsp), .nibble_stack_pointer_out(nsp), .call_push_in(callp),
        .irq_push_in(irqp), .pc_in(pc), .flags_in(flags), .push_done_out(done), .stack_fault_out(fault),
        .nmi_in(int_req), .irq_in(int_req), .nmi_out(nmi_o), .irq_out(irq_o), .irq_masked_out(masked),
        .sleep_instruction_in(sleep_instruction), .sleep_ignored_out(slp_o), .sys_ctrl_out(sys), .cust_rd_addr_out(),
        .cust_rdata_in(4'h6), .cust_wr_out(c_wr), .cust_addr_out(c_a), .cust_wdata_out(c_wd),
        .disp_rd_addr_in(d_a), .disp_rd_data_out(d_d));
    cpu_model u_cpu_model (.clk_in(clk_in), .bus_ready_in(ready), .bus_ack_in(ack), .bus_rdata_in(rdata),
        .bus_req_out(req));

    initial forever #50 clk_in = ~clk_in;

    // Registered pulses counted before the edge updates them
    always @(posedge clk_in) begin
        if (done === 1'b1) n_done++;
        if (fault === 1'b1) n_fault++;
        if (c_wr === 1'b1) last_c <= {c_a, c_wd};
    end

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        logic k;
        logic [3:0] q;
        u_cpu_model.access(1'b1, a, d, k, q);
        cmp(16'(k), 16'h1);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [3:0] e);
        logic k;
        logic [3:0] q;
        u_cpu_model.access(1'b0, a, 4'h0, k, q);
        cmp(16'({k, q}), 16'({1'b1, e}));
    endtask : rd
    task automatic load_sp(input logic w, input logic n, input logic [7:0] wv, input logic [7:0] nv);
        @(posedge clk_in);
        {wld, nld, wval, nval} <= {w, n, wv, nv};
        @(posedge clk_in);
        {wld, nld} <= 2'b00;
        #1;
    endtask : load_sp
    task automatic push(input logic is_irq, input logic [15:0] p, input logic [3:0] f);
        @(posedge clk_in);
        {callp, irqp, pc, flags} <= {!is_irq, is_irq, p, f};
        @(posedge clk_in);
        {callp, irqp} <= 2'b00;
        repeat (5) @(posedge clk_in);
        #1;
    endtask : push
    task automatic give_verdict();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    initial begin
        #1_000_000;
        n_mismatch++;
        give_verdict();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        #1 cmp(16'(masked), 16'h1);
        cmp(start_a, 16'h0110);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in) irq_num <= 3'(i);
            #1 cmp(vec, 16'h0100 + 16'(2 * i));
        end
        rd(16'hff00, 4'h0);
        rd(16'hff01, 4'h0);
        rd(16'hff02, 4'h3);
        rd(16'hff04, 4'h0);
        wr(16'hff00, 4'hf);
        rd(16'hff00, 4'hd);
        cmp(16'({sys.cpu_clock_source_sel, sys.fast_osc_on, sys.core_voltage_sel}), 16'h7);
        wr(16'hff01, 4'h5);
        rd(16'hff01, 4'h5);
        cmp(16'({sys.display_supply_sel, sys.osc_regulator_supply_sel, sys.halver_on, sys.doubler_on}), 16'h5);
        wr(16'hff02, 4'hc);
        rd(16'hff02, 4'h0);
        cmp(16'(sys.prescaler_sel), 16'h0);
        for (int i = 0; i < 16; i++) begin
            wr(16'hff04, 4'(i));
            rd(16'hff04, 4'(i));
        end
        cmp(16'(sys.detect_threshold_code), 16'hf);
        rd(16'hff02, 4'h0);
        wr(16'h0000, 4'h5);
        wr(16'h03ff, 4'ha);
        wr(16'h0400, 4'h3);
        rd(16'h0000, 4'h5);
        rd(16'h03ff, 4'ha);
        rd(16'h0400, 4'h0);
        wr(16'hf01f, 4'h9);
        rd(16'hf01f, 4'h9);
        @(posedge clk_in) d_a <= 5'h1f;
        @(posedge clk_in);
        #1 cmp(16'(d_d), 16'h9);
        wr(16'hffc5, 4'h7);
        repeat (2) @(posedge clk_in);
        #1 cmp(16'(last_c), 16'h0057);
        rd(16'hffc3, 4'h6);
        @(posedge clk_in) {rom_we, rom_a, rom_d} <= {1'b1, 16'h0110, 13'h1abc};
        @(posedge clk_in) {rom_we, fetch, faddr} <= {1'b0, 1'b1, 16'h0110};
        @(posedge clk_in) faddr <= 16'h2110;
        #1 cmp(16'({fvalid, fdata}), 16'h3abc);
        @(posedge clk_in) fetch <= 1'b0;
        #1 cmp(16'({fvalid, fdata}), 16'h0);
        @(posedge clk_in) int_req <= 1'b1;
        #1 cmp(16'({nmi_o, irq_o}), 16'h0);
        load_sp(1'b1, 1'b0, 8'h50, 8'h00);
        cmp(16'(masked), 16'h1);
        load_sp(1'b0, 1'b1, 8'h00, 8'h20);
        cmp(16'({masked, nmi_o, irq_o}), 16'h3);
        load_sp(1'b1, 1'b0, 8'h50, 8'h00);
        cmp(16'(masked), 16'h1);
        load_sp(1'b0, 1'b1, 8'h00, 8'h00);
        cmp(16'(masked), 16'h0);
        push(1'b0, 16'h1234, 4'h0);
        cmp(16'({wsp, 8'(n_done)}), 16'h4f01);
        for (int i = 0; i < 4; i++) rd(16'h013c + 16'(i), 4'(16'h1234 >> (4 * i)));
        push(1'b1, 16'h5678, 4'h9);
        cmp(16'({wsp, nsp}), 16'h4eff);
        for (int i = 0; i < 4; i++) rd(16'h0138 + 16'(i), 4'(16'h5678 >> (4 * i)));
        rd(16'h00ff, 4'h9);
        cmp(16'(n_done), 16'h2);
        load_sp(1'b1, 1'b1, 8'h00, 8'h10);
        push(1'b0, 16'h0abc, 4'h0);
        cmp(16'({wsp, 8'(n_fault)}), 16'hff01);
        @(posedge clk_in) sleep_instruction <= 1'b1;
        @(posedge clk_in) sleep_instruction <= 1'b0;
        #1 cmp(16'(slp_o), 16'h1);
        rd(16'hff01, 4'h5);
        give_verdict();
    end
endmodule : memory_map_and_system_regs_tb
